// File: rtl/net_cfg_pkg.sv
// constants, field layouts and carrier types for the common config and interrupt block
// ================================================================
// Overview of operation
// - gateway address, four bytes at 0x01
// - netmask, four bytes at 0x05
// - local hardware address, six bytes at 0x09
// - local IP address, four bytes at 0x0F
// - hold-off value delays next line assertion
// - after release, line stays high for hold-off
// - new socket event keeps line low, no release
// - host clear releases line, later flags stay
// - common flags cleared by writing one
// - nonzero common flags keep line asserted
// - address clash sets flag bit 7
// - destination lost sets flag bit 6
// - session close sets bit 5 in that mode
// - wake packet sets bit 4 when enabled
// - common mask gates flags, bits 7..4
// - summary bit n mirrors socket n flags
// - nonzero summary keeps line asserted
// - socket mask gates summary bits
// - retry time in 100us units, reset 2000
// - wait retry time after transmit, then retransmit
// - socket timeout sets bit 3 and summary
// - timeout after retry count plus one waits
// - capture failed destination IP and port
package net_cfg_pkg;

  // ================================================================
  // register byte offsets
  localparam logic [15:0] GW_ADDR_OFS      = 16'h0001; // gateway, msb first
  localparam logic [15:0] NETMASK_OFS      = 16'h0005;
  localparam logic [15:0] MAC_ADDR_OFS     = 16'h0009;
  localparam logic [15:0] IP_ADDR_OFS      = 16'h000F;
  localparam logic [15:0] HOLDOFF_OFS      = 16'h0013; // two bytes, msb first
  localparam logic [15:0] CFG_LAST_OFS     = 16'h0014; // last plain rw config byte
  localparam logic [15:0] CMN_FLAGS_OFS    = 16'h0015;
  localparam logic [15:0] CMN_MASK_OFS     = 16'h0016;
  localparam logic [15:0] SOCK_SUM_OFS     = 16'h0017;
  localparam logic [15:0] SOCK_MASK_OFS    = 16'h0018;
  localparam logic [15:0] RETRY_TIME_OFS   = 16'h0019; // two bytes, msb first
  localparam logic [15:0] RETRY_LIMIT_OFS  = 16'h001B;
  localparam logic [15:0] FAIL_IP_OFS      = 16'h0028; // four bytes read only
  localparam logic [15:0] FAIL_PORT_OFS    = 16'h002C; // two bytes read only

  // ================================================================
  // field positions and reset values
  localparam int          CLASH_BIT        = 7;
  localparam int          DEST_LOST_BIT    = 6;
  localparam int          SESSION_BIT      = 5;
  localparam int          WAKE_BIT         = 4;
  localparam int          SOCK_TIMEOUT_BIT = 3;
  localparam logic [7:0]  CMN_IMPL_MASK    = 8'hF0;   // bits 3..0 reserved, read zero
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [15:0] HOLDOFF_RST      = 16'h0000;
  localparam logic [15:0] RETRY_TIME_RST   = 16'h07D0;
  localparam logic [7:0]  RETRY_LIMIT_RST  = 8'h08;
  localparam int          NUM_SOCK         = 8;

  // ================================================================
  // timing: one retry-time unit in clock cycles
  localparam int          CLK_PERIOD_NS    = 40;
  localparam int          RETRY_UNIT_NS    = 100000;
  localparam int          RETRY_UNIT_CYC   = RETRY_UNIT_NS / CLK_PERIOD_NS;

  // ================================================================
  // carriers
  typedef struct packed {
    logic        wr;    // one-cycle write strobe
    logic        rd;    // one-cycle read strobe
    logic [15:0] addr;  // byte address
    logic [7:0]  wdata;
  } reg_req_s;

  typedef struct packed {
    logic        clash;         // arp sender ip equals local ip
    logic        dest_lost;     // icmp port unreachable seen
    logic        session_close; // pppoe session dropped
    logic        wake_packet;   // magic packet over udp
    logic [31:0] fail_ip;       // valid with dest_lost
    logic [15:0] fail_port;     // valid with dest_lost
  } net_evt_s;

  typedef struct packed {
    logic        valid; // one-cycle socket flag clear
    logic [2:0]  idx;
    logic [7:0]  bits;  // ones clear
  } sock_clr_s;

endpackage

// File: rtl/net_cfg_irq.sv
// common network config registers, event flags, interrupt line and retry timer
module net_cfg_irq (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire net_cfg_pkg::reg_req_s   reg_req,
  output logic      [7:0]              reg_rdata,
  input  wire net_cfg_pkg::net_evt_s   net_evt,
  input  wire logic                    pppoe_mode_en,
  input  wire logic                    wol_mode_en,
  input  wire logic [63:0]             sock_evt_set,
  input  wire net_cfg_pkg::sock_clr_s  sock_clr,
  output logic      [63:0]             socket_event_flags,
  input  wire logic                    retry_start,
  input  wire logic [2:0]              retry_sock,
  input  wire logic                    peer_resp,
  output logic                         retransmit,
  output logic                         event_line_low,
  output logic      [31:0]             gateway_addr,
  output logic      [31:0]             netmask_addr,
  output logic      [47:0]             local_mac_addr,
  output logic      [31:0]             local_ip_addr
);

  // ================================================================
  // state encodings
  typedef enum logic [1:0] {
    LINE_HIGH = 2'b01,  // released, hold-off running
    LINE_LOW  = 2'b10   // asserted
  } line_e;

  typedef enum logic [1:0] {
    RT_IDLE = 2'b01,
    RT_WAIT = 2'b10
  } retry_e;

  // ================================================================
  // storage
  logic [7:0]  cfg_q [1:20];     // plain rw bytes 0x01..0x14
  logic [7:0]  cmn_flags_q;      // common event flags
  logic [7:0]  cmn_mask_q;
  logic [7:0]  sock_mask_q;
  logic [15:0] retry_time_q;
  logic [7:0]  retry_limit_q;
  logic [31:0] fail_ip_q;
  logic [15:0] fail_port_q;
  logic [7:0]  sock_flags_q [0:7];
  logic [7:0]  rdata_q;
  line_e       line_q;
  logic [15:0] hold_cnt_q;       // cycles since release, saturates
  retry_e      rt_q;
  logic [11:0] unit_cnt_q;       // cycles within one 100us unit
  logic [15:0] rt_units_q;       // units waited in this attempt
  logic [7:0]  retx_cnt_q;       // retransmissions done
  logic [2:0]  rt_sock_q;
  logic        retx_q;

  // ================================================================
  // address decode
  wire         wr         = reg_req.wr;
  wire  [15:0] addr       = reg_req.addr;
  wire  [7:0]  wdata      = reg_req.wdata;
  wire         cfg_hit    = (addr >= net_cfg_pkg::GW_ADDR_OFS) && (addr <= net_cfg_pkg::CFG_LAST_OFS);
  wire         flags_wr   = wr && (addr == net_cfg_pkg::CMN_FLAGS_OFS);
  wire         cmask_wr   = wr && (addr == net_cfg_pkg::CMN_MASK_OFS);
  wire         smask_wr   = wr && (addr == net_cfg_pkg::SOCK_MASK_OFS);
  wire         rt_hi_wr   = wr && (addr == net_cfg_pkg::RETRY_TIME_OFS);
  wire         rt_lo_wr   = wr && (addr == net_cfg_pkg::RETRY_TIME_OFS + 16'h0001);
  wire         rlim_wr    = wr && (addr == net_cfg_pkg::RETRY_LIMIT_OFS);
  wire  [4:0]  cfg_idx    = addr[4:0];

  // ================================================================
  // config byte views, most significant byte at the lowest address
  wire  [15:0] holdoff    = {cfg_q[19], cfg_q[20]};

  assign gateway_addr   = {cfg_q[1], cfg_q[2], cfg_q[3], cfg_q[4]};
  assign netmask_addr   = {cfg_q[5], cfg_q[6], cfg_q[7], cfg_q[8]};
  assign local_mac_addr = {cfg_q[9], cfg_q[10], cfg_q[11], cfg_q[12], cfg_q[13], cfg_q[14]};
  assign local_ip_addr  = {cfg_q[15], cfg_q[16], cfg_q[17], cfg_q[18]};

  // config bytes: one process, all reset to zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 1; i <= 20; i++) begin
        cfg_q[i] <= net_cfg_pkg::BYTE_ZERO;
      end
    end else if (wr && cfg_hit) begin
      cfg_q[cfg_idx] <= wdata;
    end
  end

  // ================================================================
  // common event flags
  wire         sess_set   = net_evt.session_close && pppoe_mode_en;
  wire         wake_set   = net_evt.wake_packet && wol_mode_en;
  wire  [7:0]  cmn_set    = {net_evt.clash, net_evt.dest_lost, sess_set, wake_set, 4'h0};
  wire  [7:0]  cmn_clr    = flags_wr ? (wdata & net_cfg_pkg::CMN_IMPL_MASK) : 8'h00;
  // set wins over a clear landing in the same cycle
  wire  [7:0]  cmn_flags_d = (cmn_flags_q & ~cmn_clr) | cmn_set;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmn_flags_q <= net_cfg_pkg::BYTE_ZERO;
    end else begin
      cmn_flags_q <= cmn_flags_d;
    end
  end

  // failed destination captured with the unreachable event
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_ip_q   <= 32'h0000_0000;
      fail_port_q <= 16'h0000;
    end else if (net_evt.dest_lost) begin
      fail_ip_q   <= net_evt.fail_ip;
      fail_port_q <= net_evt.fail_port;
    end
  end

  // masks and retry settings
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmn_mask_q    <= net_cfg_pkg::BYTE_ZERO;
      sock_mask_q   <= net_cfg_pkg::BYTE_ZERO;
      retry_time_q  <= net_cfg_pkg::RETRY_TIME_RST;
      retry_limit_q <= net_cfg_pkg::RETRY_LIMIT_RST;
    end else begin
      if (cmask_wr) begin
        cmn_mask_q <= wdata & net_cfg_pkg::CMN_IMPL_MASK;
      end
      if (smask_wr) begin
        sock_mask_q <= wdata;
      end
      if (rt_hi_wr) begin
        retry_time_q[15:8] <= wdata;
      end
      if (rt_lo_wr) begin
        retry_time_q[7:0] <= wdata;
      end
      if (rlim_wr) begin
        retry_limit_q <= wdata;
      end
    end
  end

  // ================================================================
  // socket flags and summary
  logic [7:0] summary;
  logic       timeout_evt;  // final retry timeout, one cycle
  logic [7:0] sock_clr_hit; // clear that removed a set, enabled bit

  // one flag byte per socket; set wins over clear
  for (genvar s = 0; s < net_cfg_pkg::NUM_SOCK; s++) begin : g_sock
    wire       clr_me = sock_clr.valid && (sock_clr.idx == 3'(s));
    wire [7:0] clr_b  = clr_me ? sock_clr.bits : 8'h00;
    wire       to_me  = timeout_evt && (rt_sock_q == 3'(s));
    wire [7:0] set_b  = sock_evt_set[8*s +: 8] | (to_me ? 8'(1 << net_cfg_pkg::SOCK_TIMEOUT_BIT) : 8'h00);

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        sock_flags_q[s] <= net_cfg_pkg::BYTE_ZERO;
      end else begin
        sock_flags_q[s] <= (sock_flags_q[s] & ~clr_b) | set_b;
      end
    end

    assign summary[s]               = |sock_flags_q[s];
    assign sock_clr_hit[s]          = |(clr_b & sock_flags_q[s]) && sock_mask_q[s];
    assign socket_event_flags[8*s +: 8] = sock_flags_q[s];
  end

  // ================================================================
  // interrupt line
  wire cmn_req  = |(cmn_flags_q & cmn_mask_q);
  wire sock_req = |(summary & sock_mask_q);
  wire irq_req  = cmn_req || sock_req;
  // a host clear of an enabled, set flag ends the current assertion
  // even while other flags stand; the hold-off then decides when the
  // line may fall again, so the host sees a fresh edge per event
  wire host_clr = |(cmn_clr & cmn_flags_q & cmn_mask_q) || (|sock_clr_hit);
  wire hold_ok  = (hold_cnt_q >= holdoff);

  // line state: low only with a request and an expired hold-off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_q <= LINE_HIGH;
    end else begin
      case (line_q)
        LINE_HIGH: begin
          if (irq_req && hold_ok) begin
            line_q <= LINE_LOW;
          end
        end
        LINE_LOW: begin
          // stays low until a host clear or until no enabled flag stands; new events never release it
          if (host_clr || !irq_req) begin
            line_q <= LINE_HIGH;
          end
        end
        default: line_q <= LINE_HIGH;
      endcase
    end
  end

  // hold-off counter restarts on every release and saturates
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_q <= 16'h0000;
    end else if (line_q == LINE_LOW) begin
      hold_cnt_q <= 16'h0000;
    end else if (hold_cnt_q != 16'hFFFF) begin
      hold_cnt_q <= hold_cnt_q + 16'h0001;
    end
  end

  assign event_line_low = (line_q == LINE_HIGH);  // high level = released

  // ================================================================
  // retry timer: one wait at a time, 100us units
  // limitation: only one socket waits at a time; a start while a wait
  // runs is dropped, so the caller must serialise its sends
  // every attempt waits the same time; no doubling between attempts
  wire unit_tick = (unit_cnt_q == 12'(net_cfg_pkg::RETRY_UNIT_CYC - 1));
  wire expired   = unit_tick && (rt_units_q + 16'h0001 >= retry_time_q);
  wire final_to  = expired && (retx_cnt_q == retry_limit_q);

  assign timeout_evt = (rt_q == RT_WAIT) && !peer_resp && final_to;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rt_q       <= RT_IDLE;
      unit_cnt_q <= 12'h000;
      rt_units_q <= 16'h0000;
      retx_cnt_q <= 8'h00;
      rt_sock_q  <= 3'b000;
      retx_q     <= 1'b0;
    end else begin
      retx_q <= 1'b0;
      case (rt_q)
        RT_IDLE: begin
          if (retry_start) begin
            rt_q       <= RT_WAIT;
            rt_sock_q  <= retry_sock;
            unit_cnt_q <= 12'h000;
            rt_units_q <= 16'h0000;
            retx_cnt_q <= 8'h00;
          end
        end
        RT_WAIT: begin
          unit_cnt_q <= unit_tick ? 12'h000 : unit_cnt_q + 12'h001;
          if (peer_resp) begin
            rt_q <= RT_IDLE;        // answer arrived in time
          end else if (final_to) begin
            rt_q <= RT_IDLE;
          end else if (expired) begin
            retx_q     <= 1'b1;
            retx_cnt_q <= retx_cnt_q + 8'h01;
            rt_units_q <= 16'h0000;
          end else if (unit_tick) begin
            rt_units_q <= rt_units_q + 16'h0001;
          end
        end
        default: rt_q <= RT_IDLE;
      endcase
    end
  end

  assign retransmit = retx_q;

  // ================================================================
  // read path, registered; reads have no side effect
  // the read strobe latches one byte, which then holds until the next
  // read, so multi-byte values are read byte by byte with no snapshot
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = net_cfg_pkg::BYTE_ZERO;  // unmapped reads zero
    if (cfg_hit) begin
      rd_mux = cfg_q[cfg_idx];
    end else begin
      case (addr)
        net_cfg_pkg::CMN_FLAGS_OFS:            rd_mux = cmn_flags_q;
        net_cfg_pkg::CMN_MASK_OFS:             rd_mux = cmn_mask_q;
        net_cfg_pkg::SOCK_SUM_OFS:             rd_mux = summary;
        net_cfg_pkg::SOCK_MASK_OFS:            rd_mux = sock_mask_q;
        net_cfg_pkg::RETRY_TIME_OFS:           rd_mux = retry_time_q[15:8];
        net_cfg_pkg::RETRY_TIME_OFS + 16'h0001: rd_mux = retry_time_q[7:0];
        net_cfg_pkg::RETRY_LIMIT_OFS:          rd_mux = retry_limit_q;
        net_cfg_pkg::FAIL_IP_OFS:              rd_mux = fail_ip_q[31:24];
        net_cfg_pkg::FAIL_IP_OFS + 16'h0001:   rd_mux = fail_ip_q[23:16];
        net_cfg_pkg::FAIL_IP_OFS + 16'h0002:   rd_mux = fail_ip_q[15:8];
        net_cfg_pkg::FAIL_IP_OFS + 16'h0003:   rd_mux = fail_ip_q[7:0];
        net_cfg_pkg::FAIL_PORT_OFS:            rd_mux = fail_port_q[15:8];
        net_cfg_pkg::FAIL_PORT_OFS + 16'h0001: rd_mux = fail_port_q[7:0];
        default:                               rd_mux = net_cfg_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= net_cfg_pkg::BYTE_ZERO;
    end else if (reg_req.rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;

  // ================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // a one written clears a set flag unless the event repeats
  w1c_clear_a: assert property (flags_wr && wdata[7] && !net_evt.clash |=> !cmn_flags_q[7])
    else $error("common flag not cleared by write one");
  // zeros written leave flags alone
  w1c_keep_a: assert property (flags_wr && (wdata == 8'h00) |=> cmn_flags_q == $past(cmn_flags_q | cmn_set))
    else $error("write zero changed common flags");
  clash_set_a: assert property (net_evt.clash |=> cmn_flags_q[7])
    else $error("clash event lost");
  wake_gate_a: assert property (net_evt.wake_packet && !wol_mode_en && !cmn_flags_q[4]
                                && !(flags_wr && wdata[4]) |=> !cmn_flags_q[4])
    else $error("wake flag set with mode off");
  line_cause_a: assert property (!event_line_low |-> $past(irq_req))
    else $error("line low without enabled request");
  holdoff_a: assert property ($fell(event_line_low) |-> $past(hold_cnt_q) >= $past(holdoff))
    else $error("line asserted before hold-off");
  // a socket 0 event must show in the summary one cycle later
  summary_a: assert property (|sock_evt_set[7:0] |=> summary[0])
    else $error("summary disagrees with socket flags");
  timeout_a: assert property (timeout_evt |=> sock_flags_q[rt_sock_q][3] && summary[$past(rt_sock_q)])
    else $error("timeout did not set socket flag");
  capture_a: assert property (net_evt.dest_lost |=> fail_ip_q == $past(net_evt.fail_ip))
    else $error("failed destination not captured");
  sticky_low_a: assert property (!event_line_low && irq_req && !host_clr |=> !event_line_low)
    else $error("line released without host clear");

  // main scenarios: first assertion, release and re-assert after the
  // hold-off, a second socket event while low, a resend, a final timeout
  assert_low_c:   cover property ($fell(event_line_low));
  release_c:      cover property (!event_line_low && host_clr ##1 event_line_low ##[1:40] !event_line_low);
  sock_pend_c:    cover property (!event_line_low && $rose(summary[1]));
  resend_c:       cover property (retx_q);
  retry_final_c:  cover property (timeout_evt);

endmodule

// File: testbench/peer_model.sv
// network peer stand-in that answers retried packets after a set delay
module peer_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        retry_start,
  input  wire logic        retransmit,
  input  wire logic [15:0] resp_delay,
  output logic             peer_resp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ================================================================
  // answer timer
  logic [15:0] wait_q; // cycles left until the answer pulse

  // a zero delay keeps the peer silent, which forces retries and a timeout
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q    <= 16'h0000;
      peer_resp <= 1'b0;
    end else begin
      peer_resp <= (wait_q == 16'h0001);
      if ((retry_start || retransmit) && resp_delay != 16'h0000) begin
        wait_q <= resp_delay;
      end else if (wait_q != 16'h0000) begin
        wait_q <= wait_q - 16'h0001;
      end
    end
  end
endmodule

// File: testbench/tb_common_net_config_and_interrupts.sv
// self-checking bench for the common config and interrupt block
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module tb_common_net_config_and_interrupts;
  timeunit 1ns;
  timeprecision 1ps;
  // ================================================================
  // signals
  logic                     clk;
  logic                     nrst;
  net_cfg_pkg::reg_req_s    reg_req;
  logic [7:0]               reg_rdata;
  net_cfg_pkg::net_evt_s    net_evt;
  logic                     pppoe_mode_en;
  logic                     wol_mode_en;
  logic [63:0]              sock_evt_set;
  net_cfg_pkg::sock_clr_s   sock_clr;
  logic [63:0]              socket_event_flags;
  logic                     retry_start;
  logic [2:0]               retry_sock;  // socket whose packet waits
  logic                     peer_resp;
  logic                     retransmit;
  logic                     event_line_low;
  logic [31:0]              gateway_addr;
  logic [31:0]              netmask_addr;
  logic [47:0]              local_mac_addr;
  logic [31:0]              local_ip_addr;
  logic [15:0]              resp_delay;  // peer answer delay, zero = silent
  int                       err_count;
  int                       total_checks;
  int                       cyc;         // watchdog cycle count
  int                       rtx_count;   // retransmit pulses seen
  int                       n;

  net_cfg_irq dut (.clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata), .net_evt(net_evt),
    .pppoe_mode_en(pppoe_mode_en), .wol_mode_en(wol_mode_en), .sock_evt_set(sock_evt_set),
    .sock_clr(sock_clr), .socket_event_flags(socket_event_flags), .retry_start(retry_start),
    .retry_sock(retry_sock), .peer_resp(peer_resp), .retransmit(retransmit), .event_line_low(event_line_low),
    .gateway_addr(gateway_addr), .netmask_addr(netmask_addr), .local_mac_addr(local_mac_addr),
    .local_ip_addr(local_ip_addr));
  peer_model peer (.clk(clk), .nrst(nrst), .retry_start(retry_start), .retransmit(retransmit),
    .resp_delay(resp_delay), .peer_resp(peer_resp));

  // ================================================================
  // clock, watchdog and retransmit monitor
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // the longest run is two retry sweeps of some 5200 cycles plus register traffic
  always @(posedge clk) begin
    cyc++;
    if (retransmit === 1'b1) rtx_count++;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end

  // ================================================================
  // access tasks: strobes rise after an edge and drop after the taking edge
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  // read data is registered, so it is sampled one edge after the taking edge
  task automatic chk_reg(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(nm, e, reg_rdata)
  endtask
  // one-cycle event pulses, order clash, lost, close, wake
  task automatic pulse_evt(input logic [3:0] sel);
    @(posedge clk);
    {net_evt.clash, net_evt.dest_lost, net_evt.session_close, net_evt.wake_packet} <= sel;
    @(posedge clk);
    {net_evt.clash, net_evt.dest_lost, net_evt.session_close, net_evt.wake_packet} <= 4'h0;
  endtask
  task automatic sock_set(input int s, input logic [7:0] b);
    @(posedge clk);
    sock_evt_set <= {56'h0000_0000_0000_00, b} << (8 * s);
    @(posedge clk);
    sock_evt_set <= 64'h0000_0000_0000_0000;
  endtask
  task automatic sock_clear(input int s, input logic [7:0] b);
    @(posedge clk);
    sock_clr <= '{valid: 1'b1, idx: 3'(s), bits: b};
    @(posedge clk);
    sock_clr.valid <= 1'b0;
  endtask
  // bounded wait for a line level, returns the cycles spent
  task automatic wait_line(input logic lvl, output int k);
    k = 0;
    while (event_line_low !== lvl && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ================================================================
  // main sequence
  initial begin
    reg_req = '0;
    net_evt = '0;
    pppoe_mode_en = 1'b0;
    wol_mode_en = 1'b0;
    sock_evt_set = 64'h0000_0000_0000_0000;
    sock_clr = '0;
    retry_start = 1'b0;
    retry_sock = 3'h0;
    resp_delay = 16'h0000;
    nrst = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // reset values, unmapped places read zero
    for (int a = 0; a <= 8'h30; a++) begin
      chk_reg("reset", 16'(a), a == 8'h19 ? 8'h07 : a == 8'h1A ? 8'hD0 : a == 8'h1B ? 8'h08 : 8'h00);
    end
    `CHK("line idle", 1'b1, event_line_low)
    $display("test reset done");
    // plain config bytes, msb at the lowest address
    for (int a = 1; a <= 8'h14; a++) wr_reg(16'(a), 8'(a) + 8'h30);
    for (int a = 1; a <= 8'h14; a++) chk_reg("cfg rw", 16'(a), 8'(a) + 8'h30);
    `CHK("gateway", 32'h3132_3334, gateway_addr)
    `CHK("netmask", 32'h3536_3738, netmask_addr)
    `CHK("mac", 48'h393A_3B3C_3D3E, local_mac_addr)
    `CHK("ip", 32'h3F40_4142, local_ip_addr)
    wr_reg(16'h0013, 8'h00);
    wr_reg(16'h0014, 8'h00);
    wr_reg(16'h0016, 8'hFF);
    chk_reg("mask rsvd", 16'h0016, 8'hF0);
    wr_reg(16'h0017, 8'hFF);
    chk_reg("summary ro", 16'h0017, 8'h00);
    wr_reg(16'h002C, 8'hFF);
    chk_reg("port ro", 16'h002C, 8'h00);
    wr_reg(16'h0015, 8'hFF);
    chk_reg("flags w1c idle", 16'h0015, 8'h00);
    $display("test registers done");
    // common events: mode gating, capture, w1c and line hold
    pulse_evt(4'b0011);
    chk_reg("gated events", 16'h0015, 8'h00);
    `CHK("line gated", 1'b1, event_line_low)
    @(posedge clk);
    pppoe_mode_en <= 1'b1;
    wol_mode_en <= 1'b1;
    net_evt.fail_ip <= 32'hC0A8_000B;
    net_evt.fail_port <= 16'h1234;
    pulse_evt(4'b1111);
    chk_reg("flags set", 16'h0015, 8'hF0);
    for (int a = 0; a < 6; a++) chk_reg("fail dest", 16'h0028 + 16'(a), 8'(48'hC0A8_000B_1234 >> (40 - 8 * a)));
    `CHK("line common", 1'b0, event_line_low)
    wr_reg(16'h0015, 8'h00);
    chk_reg("w1c zero", 16'h0015, 8'hF0);
    wr_reg(16'h0015, 8'h80);
    chk_reg("w1c one", 16'h0015, 8'h70);
    wait_line(1'b0, n);
    `CHK("line pending", 1'b0, event_line_low)
    wr_reg(16'h0015, 8'h70);
    wait_line(1'b1, n);
    `CHK("line cleared", 1'b1, event_line_low)
    wr_reg(16'h0016, 8'h00);
    pulse_evt(4'b1000);
    repeat (10) @(posedge clk);
    #1;
    `CHK("line masked", 1'b1, event_line_low)
    wr_reg(16'h0015, 8'h80);
    $display("test common events done");
    // socket events and the hold-off after release
    wr_reg(16'h0014, 8'h14);
    wr_reg(16'h0018, 8'h03);
    sock_set(0, 8'h08);
    wait_line(1'b0, n);
    `CHK("line sock0", 1'b0, event_line_low)
    sock_set(1, 8'h01);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #1;
      `CHK("line held", 1'b0, event_line_low)
    end
    chk_reg("summary two", 16'h0017, 8'h03);
    `CHK("sock flags", 16'h0108, socket_event_flags[15:0])
    sock_clear(0, 8'h08);
    wait_line(1'b1, n);
    `CHK("line release", 1'b1, event_line_low)
    wait_line(1'b0, n);
    `CHK("holdoff gap", 1'b1, n >= 19 && n <= 23)
    chk_reg("summary kept", 16'h0017, 8'h02);
    sock_clear(1, 8'h01);
    wait_line(1'b1, n);
    `CHK("line sum zero", 1'b1, event_line_low)
    wr_reg(16'h0018, 8'hFE);
    sock_set(0, 8'h08);
    repeat (40) @(posedge clk);
    #1;
    `CHK("line sock mask", 1'b1, event_line_low)
    chk_reg("summary masked", 16'h0017, 8'h01);
    sock_clear(0, 8'h08);
    $display("test sockets done");
    // retry timer: one unit per wait, one retransmission, then timeout
    wr_reg(16'h0018, 8'h01);
    wr_reg(16'h0019, 8'h00);
    wr_reg(16'h001A, 8'h01);
    wr_reg(16'h001B, 8'h01);
    rtx_count = 0;
    @(posedge clk);
    retry_start <= 1'b1;
    @(posedge clk);
    retry_start <= 1'b0;
    repeat (2400) @(posedge clk);
    `CHK("no early resend", 0, rtx_count)
    repeat (200) @(posedge clk);
    `CHK("one resend", 1, rtx_count)
    repeat (2600) @(posedge clk);
    `CHK("resend count", 1, rtx_count)
    `CHK("timeout flag", 8'h08, socket_event_flags[7:0])
    `CHK("timeout line", 1'b0, event_line_low)
    chk_reg("timeout summary", 16'h0017, 8'h01);
    sock_clear(0, 8'h08);
    retry_sock <= 3'h2;
    resp_delay <= 16'h0064;
    rtx_count = 0;
    @(posedge clk);
    retry_start <= 1'b1;
    @(posedge clk);
    retry_start <= 1'b0;
    repeat (5200) @(posedge clk);
    `CHK("answered resend", 0, rtx_count)
    `CHK("answered flags", 8'h00, socket_event_flags[23:16])
    $display("test retry done");
    summarize();
  end
endmodule
